// [logic/packed_simd_integer_alu.v]
// Behaviour
// - Wraparound keeps low bits, drops carry
// - Signed bytes clamp to 80H..7FH
// - Signed words clamp to 8000H..7FFFH
// - Unsigned clamp bytes 00..FF, words 0000..FFFF
// - Overflow gives maximum, underflow gives minimum
// - No exception or flag on overflow
// - Two operands: destination also a source
// - Result overwrites the destination register
// - Source from memory or register; dest register
// - 32-bit move memory/integer to/from register
// - 64-bit move memory/register, register to register
// - Wrap add/sub on bytes, words, doublewords
// - Signed saturating add/sub on bytes, words
// - Unsigned saturating add/sub on bytes, words
// - Four signed 16-bit products, 32-bit wide
// - Multiply high/low keeps upper/lower 16 bits
// - Multiply-add sums adjacent products into doublewords
// - Lane 0 at least significant bits
// - Eight 64-bit packed operand registers
// - Memory data little endian, low byte first
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"

module packed_simd_integer_alu #(
    parameter NUM_REGS = `NUM_PACKED_REGS,
    parameter IDX_W    = `REG_IDX_W
) (
    // Clock and reset
    input  wire             clk_sys_in,
    input  wire             rst_n_in,
    // Operation request from the decoder
    input  wire             op_valid_in,
    input  wire [4:0]       op_in,
    input  wire [IDX_W-1:0] dst_idx_in,
    input  wire [IDX_W-1:0] src_idx_in,
    input  wire             src_is_mem_in,
    // Memory load data, byte 0 from the lowest address in bits 7:0
    input  wire [63:0]      mem_data_in,
    // Integer register value for the 32-bit move
    input  wire [31:0]      int_data_in,
    // Store / integer-register results
    output reg              store_valid_out,
    output reg  [63:0]      store_data_out,
    output reg  [7:0]       store_byte_en_out,
    output reg              int_wr_valid_out,
    output reg  [31:0]      int_wr_data_out,
    // Write-back observation
    output reg              wb_valid_out,
    output reg  [IDX_W-1:0] wb_idx_out,
    output reg  [63:0]      wb_data_out
);

////////////////////////////////////////////////////////////////////////////////
// Packed operand registers
reg  [63:0] packed_regs_reg [0:NUM_REGS-1];

wire [63:0] dst_val = packed_regs_reg[dst_idx_in];
// Source chosen between memory and register file
wire [63:0] src_val = src_is_mem_in ? mem_data_in : packed_regs_reg[src_idx_in];

////////////////////////////////////////////////////////////////////////////////
// Decode add/sub controls
reg        sub_sel;
reg  [1:0] esize_sel;
reg  [1:0] sat_sel;

always @* begin
    sub_sel   = 1'b0;
    esize_sel = `ESIZE_BYTE;
    sat_sel   = `SAT_WRAP;
    case (op_in)
        `OP_ADD_BYTES_WRAP: begin
            esize_sel = `ESIZE_BYTE;
        end
        `OP_ADD_WORDS_WRAP: begin
            esize_sel = `ESIZE_WORD;
        end
        `OP_ADD_DWORDS_WRAP: begin
            esize_sel = `ESIZE_DWORD;
        end
        `OP_SUB_BYTES_WRAP: begin
            sub_sel   = 1'b1;
            esize_sel = `ESIZE_BYTE;
        end
        `OP_SUB_WORDS_WRAP: begin
            sub_sel   = 1'b1;
            esize_sel = `ESIZE_WORD;
        end
        `OP_SUB_DWORDS_WRAP: begin
            sub_sel   = 1'b1;
            esize_sel = `ESIZE_DWORD;
        end
        `OP_ADD_BYTES_SSAT: begin
            sat_sel = `SAT_SIGNED;
        end
        `OP_ADD_WORDS_SSAT: begin
            sat_sel   = `SAT_SIGNED;
            esize_sel = `ESIZE_WORD;
        end
        `OP_SUB_BYTES_SSAT: begin
            sat_sel = `SAT_SIGNED;
            sub_sel = 1'b1;
        end
        `OP_SUB_WORDS_SSAT: begin
            sat_sel   = `SAT_SIGNED;
            sub_sel   = 1'b1;
            esize_sel = `ESIZE_WORD;
        end
        `OP_ADD_BYTES_USAT: begin
            sat_sel = `SAT_UNSIGNED;
        end
        `OP_ADD_WORDS_USAT: begin
            sat_sel   = `SAT_UNSIGNED;
            esize_sel = `ESIZE_WORD;
        end
        `OP_SUB_BYTES_USAT: begin
            sat_sel = `SAT_UNSIGNED;
            sub_sel = 1'b1;
        end
        `OP_SUB_WORDS_USAT: begin
            sat_sel   = `SAT_UNSIGNED;
            sub_sel   = 1'b1;
            esize_sel = `ESIZE_WORD;
        end
        default: begin
            sub_sel = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Arithmetic units; lanes packed from bit 0 upward
wire [63:0] addsub_res;
wire [63:0] mul_high;
wire [63:0] mul_low;
wire [63:0] mul_pairs;

// Clamping per lane, carries cut at lane edges
packed_lane_adder u_adder (
    .dst_in   (dst_val),
    .src_in   (src_val),
    .sub_in   (sub_sel),
    .esize_in (esize_sel),
    .sat_in   (sat_sel),
    .sum_out  (addsub_res)
);

packed_word_multiplier u_mul (
    .dst_in       (dst_val),
    .src_in       (src_val),
    .high_out     (mul_high),
    .low_out      (mul_low),
    .pair_sum_out (mul_pairs)
);

////////////////////////////////////////////////////////////////////////////////
// Result select and destination of the result
reg [63:0] result_next;
reg        reg_wr_next;
reg        store_next;
reg        int_wr_next;

always @* begin
    result_next = addsub_res;
    reg_wr_next = 1'b1;
    store_next  = 1'b0;
    int_wr_next = 1'b0;
    case (op_in)
        `OP_NOP: begin
            reg_wr_next = 1'b0;
        end
        `OP_MUL_HIGH: begin
            result_next = mul_high;
        end
        `OP_MUL_LOW: begin
            result_next = mul_low;
        end
        `OP_MUL_ADD_PAIRS: begin
            result_next = mul_pairs;
        end
        `OP_MOVE_64BIT: begin
            result_next = src_val;
        end
        `OP_MOVE_32BIT_IN: begin
            // Upper half cleared; memory or integer register feeds the low half
            result_next = {32'h00000000,
                           src_is_mem_in ? mem_data_in[31:0] : int_data_in};
        end
        `OP_MOVE_32BIT_OUT: begin
            reg_wr_next = 1'b0;
            store_next  = src_is_mem_in;
            int_wr_next = ~src_is_mem_in;
            result_next = dst_val;
        end
        `OP_MOVE_64BIT_OUT: begin
            reg_wr_next = 1'b0;
            store_next  = 1'b1;
            result_next = dst_val;
        end
        default: begin
            result_next = addsub_res;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Write-back and output registers; no flag or trap path exists at all
integer i;

always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        for (i = 0; i < NUM_REGS; i = i + 1) begin
            packed_regs_reg[i] <= 64'h0000000000000000;
        end
        wb_valid_out      <= 1'b0;
        wb_idx_out        <= {IDX_W{1'b0}};
        wb_data_out       <= 64'h0000000000000000;
        store_valid_out   <= 1'b0;
        store_data_out    <= 64'h0000000000000000;
        store_byte_en_out <= 8'h00;
        int_wr_valid_out  <= 1'b0;
        int_wr_data_out   <= 32'h00000000;
    end else begin
        wb_valid_out     <= op_valid_in && reg_wr_next;
        store_valid_out  <= op_valid_in && store_next;
        int_wr_valid_out <= op_valid_in && int_wr_next;
        if (op_valid_in && reg_wr_next) begin
            packed_regs_reg[dst_idx_in] <= result_next;
            wb_idx_out                  <= dst_idx_in;
            wb_data_out                 <= result_next;
        end
        if (op_valid_in && store_next) begin
            // Byte 0 goes to the lowest address lane
            store_data_out    <= result_next;
            store_byte_en_out <= (op_in == `OP_MOVE_32BIT_OUT) ? 8'h0F : 8'hFF;
        end
        if (op_valid_in && int_wr_next) begin
            int_wr_data_out <= result_next[31:0];
        end
    end
end

endmodule // packed_simd_integer_alu
`default_nettype wire

// [logic/simd_alu_map.vh]
`ifndef SIMD_ALU_MAP_VH
`define SIMD_ALU_MAP_VH
// Operation codes (op_in)
`define OP_NOP              5'h00
`define OP_ADD_BYTES_WRAP   5'h01
`define OP_ADD_WORDS_WRAP   5'h02
`define OP_ADD_DWORDS_WRAP  5'h03
`define OP_SUB_BYTES_WRAP   5'h04
`define OP_SUB_WORDS_WRAP   5'h05
`define OP_SUB_DWORDS_WRAP  5'h06
`define OP_ADD_BYTES_SSAT   5'h07
`define OP_ADD_WORDS_SSAT   5'h08
`define OP_SUB_BYTES_SSAT   5'h09
`define OP_SUB_WORDS_SSAT   5'h0A
`define OP_ADD_BYTES_USAT   5'h0B
`define OP_ADD_WORDS_USAT   5'h0C
`define OP_SUB_BYTES_USAT   5'h0D
`define OP_SUB_WORDS_USAT   5'h0E
`define OP_MUL_HIGH         5'h0F
`define OP_MUL_LOW          5'h10
`define OP_MUL_ADD_PAIRS    5'h11
`define OP_MOVE_64BIT       5'h12
`define OP_MOVE_32BIT_IN    5'h13
`define OP_MOVE_32BIT_OUT   5'h14
`define OP_MOVE_64BIT_OUT   5'h15
// Element size codes for the lane adder
`define ESIZE_BYTE          2'h0
`define ESIZE_WORD          2'h1
`define ESIZE_DWORD         2'h2
// Saturation mode codes
`define SAT_WRAP            2'h0
`define SAT_SIGNED          2'h1
`define SAT_UNSIGNED        2'h2
// Clamp limits
`define SBYTE_MAX           8'h7F
`define SBYTE_MIN           8'h80
`define SWORD_MAX           16'h7FFF
`define SWORD_MIN           16'h8000
`define UBYTE_MAX           8'hFF
`define UBYTE_MIN           8'h00
`define UWORD_MAX           16'hFFFF
`define UWORD_MIN           16'h0000
// Register file geometry
`define NUM_PACKED_REGS     8
`define REG_IDX_W           3
`endif

// [logic/packed_lane_adder.v]
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"

module packed_lane_adder (
    // Operands
    input  wire [63:0] dst_in,
    input  wire [63:0] src_in,
    // Control
    input  wire        sub_in,
    input  wire [1:0]  esize_in,
    input  wire [1:0]  sat_in,
    // Result
    output reg  [63:0] sum_out
);

////////////////////////////////////////////////////////////////////////////////
// Byte, word and doubleword lanes computed separately, one generate loop each
wire [63:0] byte_res;
wire [63:0] word_res;
wire [63:0] dword_res;

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_byte
        wire [7:0] a = dst_in[gi*8 +: 8];
        wire [7:0] b = src_in[gi*8 +: 8];
        // Nine-bit result keeps the carry inside this lane only
        wire [8:0] r = sub_in ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
        wire       s_ovf = sub_in ? ((a[7] != b[7]) && (r[7] != a[7]))
                                  : ((a[7] == b[7]) && (r[7] != a[7]));
        reg  [7:0] o;
        always @* begin
            o = r[7:0];
            if (sat_in == `SAT_SIGNED && s_ovf) begin
                o = a[7] ? `SBYTE_MIN : `SBYTE_MAX;
            end else if (sat_in == `SAT_UNSIGNED && r[8]) begin
                o = sub_in ? `UBYTE_MIN : `UBYTE_MAX;
            end
        end
        assign byte_res[gi*8 +: 8] = o;
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_word
        wire [15:0] a = dst_in[gi*16 +: 16];
        wire [15:0] b = src_in[gi*16 +: 16];
        wire [16:0] r = sub_in ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
        wire        s_ovf = sub_in ? ((a[15] != b[15]) && (r[15] != a[15]))
                                   : ((a[15] == b[15]) && (r[15] != a[15]));
        reg  [15:0] o;
        always @* begin
            o = r[15:0];
            if (sat_in == `SAT_SIGNED && s_ovf) begin
                o = a[15] ? `SWORD_MIN : `SWORD_MAX;
            end else if (sat_in == `SAT_UNSIGNED && r[16]) begin
                o = sub_in ? `UWORD_MIN : `UWORD_MAX;
            end
        end
        assign word_res[gi*16 +: 16] = o;
    end
    // Doublewords only ever wrap
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_dword
        wire [31:0] a = dst_in[gi*32 +: 32];
        wire [31:0] b = src_in[gi*32 +: 32];
        assign dword_res[gi*32 +: 32] = sub_in ? (a - b) : (a + b);
    end
endgenerate

// Pick lane width
always @* begin
    case (esize_in)
        `ESIZE_BYTE:  sum_out = byte_res;
        `ESIZE_WORD:  sum_out = word_res;
        `ESIZE_DWORD: sum_out = dword_res;
        default:      sum_out = 64'h0000000000000000;
    endcase
end

endmodule // packed_lane_adder
`default_nettype wire

// [logic/packed_word_multiplier.v]
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"

module packed_word_multiplier (
    // Operands
    input  wire [63:0] dst_in,
    input  wire [63:0] src_in,
    // Results
    output wire [63:0] high_out,
    output wire [63:0] low_out,
    output wire [63:0] pair_sum_out
);

////////////////////////////////////////////////////////////////////////////////
// Four signed 16x16 products, full 32 bits each
wire [127:0] prod;

genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mul
        wire signed [15:0] a = dst_in[gi*16 +: 16];
        wire signed [15:0] b = src_in[gi*16 +: 16];
        wire signed [31:0] p = a * b;
        assign prod[gi*32 +: 32]      = p;
        assign high_out[gi*16 +: 16]  = p[31:16];
        assign low_out[gi*16 +: 16]   = p[15:0];
    end
    // Adjacent pairs summed; only -32768*-32768 twice can wrap, as the format allows
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pair
        assign pair_sum_out[gi*32 +: 32] = prod[gi*64 +: 32] + prod[gi*64+32 +: 32];
    end
endgenerate

endmodule // packed_word_multiplier
`default_nettype wire

// [testbench/packed_alu_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"
module packed_alu_props #(
    parameter NUM_REGS = 8,
    parameter IDX_W    = 3
) (
    // Clock, reset and request
    input wire logic             clk_sys_in,
    input wire logic             rst_n_in,
    input wire logic             op_valid_in,
    input wire logic [4:0]       op_in,
    input wire logic [IDX_W-1:0] dst_idx_in,
    input wire logic             src_is_mem_in,
    input wire logic [63:0]      mem_data_in,
    input wire logic [31:0]      int_data_in,
    // Results
    input wire logic             store_valid_out,
    input wire logic [63:0]      store_data_out,
    input wire logic [7:0]       store_byte_en_out,
    input wire logic             int_wr_valid_out,
    input wire logic             wb_valid_out,
    input wire logic [IDX_W-1:0] wb_idx_out,
    input wire logic [63:0]      wb_data_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // Decoded requests; NOP and transfers fall outside the arithmetic range
    wire arith = op_valid_in && op_in >= `OP_ADD_BYTES_WRAP && op_in <= `OP_MUL_ADD_PAIRS;
    wire out64 = op_valid_in && op_in == `OP_MOVE_64BIT_OUT;
    wire out32 = op_valid_in && op_in == `OP_MOVE_32BIT_OUT;
    wire in32  = op_valid_in && op_in == `OP_MOVE_32BIT_IN && !src_is_mem_in;
    wire ld64  = op_valid_in && op_in == `OP_MOVE_64BIT && src_is_mem_in;
    ////////////////////////////////////////////////////////////////////////////
    wb_arith_a: assert property (
        arith |=> wb_valid_out && wb_idx_out == $past(dst_idx_in) && !store_valid_out)
        else $error("arithmetic result not written back");
    idle_quiet_a: assert property (
        !op_valid_in |=> !wb_valid_out && !store_valid_out && !int_wr_valid_out
        && $stable(wb_data_out)) else $error("output activity without request");
    store_full_a: assert property (
        out64 |=> store_valid_out && store_byte_en_out == 8'hFF && !wb_valid_out)
        else $error("64-bit store wrong");
    store_half_a: assert property (
        out32 && src_is_mem_in |=> store_valid_out && store_byte_en_out == 8'h0F)
        else $error("32-bit store wrong");
    int_out_a: assert property (
        out32 && !src_is_mem_in |=> int_wr_valid_out && !store_valid_out)
        else $error("integer write missing");
    int_in_a: assert property (
        in32 |=> wb_valid_out && wb_data_out == {32'h0, $past(int_data_in)})
        else $error("32-bit move in wrong");
    load_full_a: assert property (
        ld64 |=> wb_valid_out && wb_data_out == $past(mem_data_in))
        else $error("64-bit load wrong");
    store_back_a: assert property (
        ld64 ##1 (out64 && dst_idx_in == $past(dst_idx_in))
        |=> store_data_out == $past(mem_data_in, 2)) else $error("load not stored back");
    // Main scenarios reached
    cover property (op_valid_in && op_in == `OP_MUL_ADD_PAIRS);
    cover property (ld64 ##1 out64);
    cover property (arith ##1 arith);
endmodule // packed_alu_props
`default_nettype wire

// [testbench/load_path_model.sv]
`timescale 1ns/1ps
`default_nettype none
module load_path_model (
    // Clock and load request
    input  wire logic        clk_sys_in,
    input  wire logic        load_en_in,
    // Store traffic from the block
    input  wire logic        store_valid_in,
    input  wire logic [63:0] store_data_in,
    input  wire logic [7:0]  store_byte_en_in,
    // Load data towards the block
    output var  logic [63:0] mem_data_out
);
    logic [7:0]  mem [0:7];
    logic [63:0] last_q = 64'h0;
    // Bench writes one byte at an address
    task automatic put(input int a, input logic [7:0] b);
        mem[a] = b;
    endtask
    // Address 0 is the low byte; an idle bus shows the inverse of its last load
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            mem_data_out[8*i +: 8] = load_en_in ? mem[i] : ~last_q[8*i +: 8];
        end
    end
    // Remember the last load, take enabled store bytes
    always @(posedge clk_sys_in) begin
        if (load_en_in) last_q <= mem_data_out;
        for (int i = 0; i < 8; i++) begin
            if (store_valid_in && store_byte_en_in[i]) mem[i] <= store_data_in[8*i +: 8];
        end
    end
endmodule // load_path_model
`default_nettype wire

// [testbench/test_packed_simd_integer_alu.sv]
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_packed_simd_integer_alu;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        op_valid_in = 1'b0;
    logic [4:0]  op_in = 5'h00;
    logic [2:0]  dst_idx_in = 3'h0;
    logic [2:0]  src_idx_in = 3'h0;
    logic        src_is_mem_in = 1'b0;
    logic [31:0] int_data_in = 32'h0;
    wire  [63:0] mem_data_in, store_data_out, wb_data_out;
    wire  [31:0] int_wr_data_out;
    wire  [7:0]  store_byte_en_out;
    wire  [2:0]  wb_idx_out;
    wire         store_valid_out, int_wr_valid_out, wb_valid_out;
    int          n_mismatch = 0;
    int          n_compared = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    packed_simd_integer_alu u_packed_simd_integer_alu (.clk_sys_in, .rst_n_in, .op_valid_in,
        .op_in, .dst_idx_in, .src_idx_in, .src_is_mem_in, .mem_data_in, .int_data_in,
        .store_valid_out, .store_data_out, .store_byte_en_out, .int_wr_valid_out,
        .int_wr_data_out, .wb_valid_out, .wb_idx_out, .wb_data_out);
    // Memory answers only while a memory source is requested
    load_path_model u_load_path_model (.clk_sys_in, .load_en_in(op_valid_in & src_is_mem_in),
        .store_valid_in(store_valid_out), .store_data_in(store_data_out),
        .store_byte_en_in(store_byte_en_out), .mem_data_out(mem_data_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Valid stays up between calls so back-to-back requests never toggle it
    task automatic run_op(input logic [4:0] op, input logic [2:0] d, s, input logic m);
        op_in = op;
        dst_idx_in = d;
        src_idx_in = s;
        src_is_mem_in = m;
        op_valid_in = 1'b1;
        @(negedge clk_sys_in);
    endtask
    task automatic put_q(input logic [63:0] v);
        for (int i = 0; i < 8; i++) u_load_path_model.put(i, v[8*i +: 8]);
    endtask
    task automatic load_reg(input logic [2:0] r, input logic [63:0] v);
        put_q(v);
        run_op(`OP_MOVE_64BIT, r, 3'h0, 1'b1);
        `CHK(wb_data_out, v)
        `CHK(wb_idx_out, r)
    endtask
    // Lane model: sat 0 wrap, 1 signed, 2 unsigned
    function automatic logic [63:0] ref_add(input logic [63:0] a, b, input int sub, w, sat);
        longint x, y, r, hi, lo, m;
        logic [63:0] q;
        m = (longint'(1) << w) - 1;
        hi = sat == 1 ? m >> 1 : m;
        lo = sat == 1 ? -hi - 1 : 0;
        q = 64'h0;
        for (int i = 0; i < 64 / w; i++) begin
            x = (a >> (i * w)) & m;
            y = (b >> (i * w)) & m;
            if (sat == 1 && x > hi) x = x - m - 1;
            if (sat == 1 && y > hi) y = y - m - 1;
            r = sub ? x - y : x + y;
            if (sat != 0) r = r > hi ? hi : (r < lo ? lo : r);
            q = q | ((r & m) << (i * w));
        end
        return q;
    endfunction
    // Mode 0 high half, 1 low half, 2 pair sums
    function automatic logic [63:0] ref_mul(input logic [63:0] a, b, input int mode);
        logic signed [31:0] p [4];
        logic [63:0] q;
        for (int i = 0; i < 4; i++) p[i] = $signed(a[16*i +: 16]) * $signed(b[16*i +: 16]);
        for (int i = 0; i < 4; i++) q[16*i +: 16] = mode == 0 ? p[i][31:16] : p[i][15:0];
        if (mode == 2) q = {p[2] + p[3], p[0] + p[1]};
        return q;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // All eight registers start clear, then hold distinct values
    task automatic t_regs;
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 8; r++) begin
                run_op(`OP_MOVE_64BIT_OUT, r[2:0], 3'h0, 1'b0);
                `CHK(store_data_out, p ? {8{8'h11 * r[7:0]}} : 64'h0)
            end
            for (int r = 0; r < 8; r++) load_reg(r[2:0], {8{8'h11 * r[7:0]}});
        end
    endtask
    // Every add/sub code, register then memory source, operands swapped
    task automatic t_arith;
        logic [63:0] a = 64'h7F80_FF00_7FFF_8001;
        logic [63:0] b = 64'h01FF_0280_0001_0002;
        int j, w, sub, sat;
        for (int k = 0; k < 14; k++) begin
            j = k < 6 ? k : k - 6;
            w = k < 6 ? 8 << (j % 3) : 8 << (j % 2);
            sub = k < 6 ? j / 3 : (j / 2) % 2;
            sat = k < 6 ? 0 : 1 + j / 4;
            load_reg(3'h2, b);
            load_reg(3'h1, a);
            run_op(5'(k + 1), 3'h1, 3'h2, 1'b0);
            `CHK(wb_data_out, ref_add(a, b, sub, w, sat))
            load_reg(3'h1, b);
            put_q(a);
            run_op(5'(k + 1), 3'h1, 3'h0, 1'b1);
            `CHK(wb_data_out, ref_add(b, a, sub, w, sat))
        end
    endtask
    task automatic t_mul;
        logic [63:0] a = 64'h8000_7FFF_FFFF_1234;
        logic [63:0] b = 64'h8000_8000_0002_FFFF;
        for (int k = 0; k < 3; k++) begin
            load_reg(3'h3, a);
            put_q(b);
            run_op(5'(`OP_MUL_HIGH + k), 3'h3, 3'h0, 1'b1);
            `CHK(wb_data_out, ref_mul(a, b, k))
        end
    endtask
    // Byte order both ways, 32-bit moves, NOP leaves state alone
    task automatic t_moves;
        for (int i = 0; i < 8; i++) u_load_path_model.put(i, 8'(8'h11 * (i + 1)));
        run_op(`OP_MOVE_64BIT, 3'h4, 3'h0, 1'b1);
        `CHK(wb_data_out, 64'h8877_6655_4433_2211)
        put_q(64'h0);
        run_op(`OP_MOVE_64BIT_OUT, 3'h4, 3'h0, 1'b0);
        `CHK(store_data_out, 64'h8877_6655_4433_2211)
        int_data_in = 32'hCAFE_0001;
        run_op(`OP_MOVE_32BIT_IN, 3'h6, 3'h0, 1'b0);
        `CHK(wb_data_out, 64'h0000_0000_CAFE_0001)
        `CHK(u_load_path_model.mem[7], 8'h88)
        run_op(`OP_MOVE_32BIT_IN, 3'h6, 3'h0, 1'b1);
        `CHK(wb_data_out, 64'h0000_0000_4433_2211)
        run_op(`OP_MOVE_32BIT_OUT, 3'h4, 3'h0, 1'b0);
        `CHK(int_wr_data_out, 32'h4433_2211)
        `CHK({int_wr_valid_out, store_valid_out}, 2'b10)
        run_op(`OP_MOVE_32BIT_OUT, 3'h7, 3'h0, 1'b1);
        `CHK({store_valid_out, store_byte_en_out}, 9'h10F)
        `CHK(store_data_out, 64'h7777_7777_7777_7777)
        run_op(`OP_MOVE_64BIT, 3'h5, 3'h4, 1'b0);
        `CHK(wb_data_out, 64'h8877_6655_4433_2211)
        `CHK({u_load_path_model.mem[4], u_load_path_model.mem[3]}, 16'h5577)
        run_op(`OP_NOP, 3'h5, 3'h0, 1'b0);
        `CHK(wb_valid_out, 1'b0)
        op_valid_in = 1'b0;
        @(negedge clk_sys_in);
    endtask
    initial begin
        repeat (4) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        t_regs;
        t_arith;
        t_mul;
        t_moves;
        stop_test;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_mismatch++;
        stop_test;
    end
endmodule // test_packed_simd_integer_alu
bind packed_simd_integer_alu packed_alu_props #(.NUM_REGS(NUM_REGS), .IDX_W(IDX_W))
    u_packed_alu_props (.clk_sys_in, .rst_n_in, .op_valid_in, .op_in, .dst_idx_in,
    .src_is_mem_in, .mem_data_in, .int_data_in, .store_valid_out, .store_data_out,
    .store_byte_en_out, .int_wr_valid_out, .wb_valid_out, .wb_idx_out, .wb_data_out);
`default_nettype wire
